//--- common/adcq_params.svh
`ifndef ADCQ_PARAMS_SVH
`define ADCQ_PARAMS_SVH

// Register byte offsets
`define OFS_PORTA_DATA   8'h00
`define OFS_PORTA_DIR    8'h04
`define OFS_PORTB_DATA   8'h08
`define OFS_Q1_CTRL      8'h0c
`define OFS_Q2_CTRL      8'h10
`define OFS_STATUS       8'h14
`define OFS_MASK         8'h18
`define OFS_Q1_LEN       8'h1c
`define OFS_Q2_LEN       8'h20
`define OFS_QSTATE       8'h24

// Queue control fields
`define QC_MODE_LSB      0
`define QC_RATE_LSB      4
`define QC_PAUSE_LSB     8
`define QC_GO_BIT        16

// Status bits
`define ST_Q1_DONE       0
`define ST_Q2_DONE       1
`define ST_Q1_OVR        2
`define ST_Q2_OVR        3
`define ST_Q2_PAUSE      4

// Periodic interval: 2^(7+rate) converter clocks, rate 0..10
`define PER_EXP_MIN      7
`define PER_RATE_MAX     4'ha

// Conversion length in CLK cycles and queue length reset value
`define CONV_CYCLES      8'h0e
`define QLEN_RESET       4'hf

`endif

//--- common/adcq_pkg.sv
package adcq_pkg;
  typedef enum logic [2:0] {
    QM_OFF   = 3'h0,
    QM_SWCON = 3'h1,
    QM_RISE  = 3'h2,
    QM_FALL  = 3'h3,
    QM_PER   = 3'h4
  } qmode_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_RUN   = 4'b0010,
    ST_PAUSE = 4'b0100,
    ST_DONE  = 4'b1000
  } qstate_t;
endpackage

//--- src/adc_queue_ctrl.sv
`include "adcq_params.svh"

// Operation
// - Port A bidirectional, per-bit direction register
// - Port A drivers only pull low
// - Inputs read pins; outputs read stored data
// - Port A reads pass a synchroniser
// - Port B eight input-only bits
// - Port B reads pass a synchroniser
// - Queue 1 always wins over queue 2
// - Selectable edge on trigger pin starts queue
// - Walk command words; next edge restarts
// - Periodic timer triggers queue 2 only
// - Interval two^7 to two^17 converter clocks
// - Timer expires, triggers, reloads, keeps counting
// - Pause waits for next trigger of its queue
// - After end, next trigger restarts queue
// - Trigger while running is an overrun
// - Completion raises enabled interrupt
module adc_queue_ctrl
  import adcq_pkg::*;
#(
  parameter int CONV_LEN = 14
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  PORTA_PINS_IN,
  output logic      [7:0]  PORTA_PINS_OUT,
  output logic      [7:0]  PORTA_PINS_OE,
  input  wire logic [7:0]  PORTB_PINS,
  input  wire logic [1:0]  TRIG_PINS,
  output logic      [1:0]  CMD_INDEX1,
  output logic      [3:0]  CMD_INDEX_Q1,
  output logic      [3:0]  CMD_INDEX_Q2,
  output logic             CONV_BUSY,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]  porta_data_reg;
    logic [7:0]  porta_direction_reg;
    logic [7:0]  pa_s1;
    logic [7:0]  pa_s2;
    logic [7:0]  pb_s1;
    logic [7:0]  pb_s2;
    logic [1:0]  tr_s1;
    logic [1:0]  tr_s2;
    logic [1:0]  tr_d;
    logic [16:0] q1_ctrl;
    logic [16:0] queue2_control_reg;
    logic [3:0]  q1_len;
    logic [3:0]  q2_len;
    logic [4:0]  status;
    logic [4:0]  mask;
    qstate_t     q1_st;
    qstate_t     q2_st;
    logic [3:0]  q1_ptr;
    logic [3:0]  q2_ptr;
    logic        active_q2;
    logic        busy;
    logic        ack;
    logic [7:0]  conv_cnt;
    logic [16:0] per_cnt;
    logic [31:0] rdata;
  } state_t;

  state_t s_reg, s_next;

  // Timer reload value, one less than the interval, for a rate code, saturated at the longest setting
  function automatic logic [16:0] per_reload(input logic [3:0] rate);
    logic [3:0] r;
    r = (rate > `PER_RATE_MAX) ? `PER_RATE_MAX : rate;
    per_reload = 17'((18'h1 << (`PER_EXP_MIN + r)) - 18'h1);
  endfunction

  function automatic qmode_t mode_of(input logic [16:0] c);
    mode_of = qmode_t'(c[`QC_MODE_LSB +: 3]);
  endfunction

  logic       acc;
  logic       wr;
  logic       rd;
  logic [4:0] ev;
  logic [1:0] edge_hit;
  logic       per_tick;
  logic [1:0] trig;
  logic       conv_end;
  logic [3:0] cur_ptr;
  logic       cur_pause;
  logic       cur_last;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    acc = PSEL && PENABLE;
    // One wait state, so registered read data stands at the ready edge
    wr = acc && PWRITE && s_reg.ack;
    rd = acc && !PWRITE && !s_reg.ack;
    ev = 5'h0;
    s_next.ack = acc && !s_reg.ack;

    s_next.pa_s1 = PORTA_PINS_IN;
    s_next.pa_s2 = s_reg.pa_s1;
    s_next.pb_s1 = PORTB_PINS;
    s_next.pb_s2 = s_reg.pb_s1;
    s_next.tr_s1 = TRIG_PINS;
    s_next.tr_s2 = s_reg.tr_s1;
    s_next.tr_d  = s_reg.tr_s2;

    // Edge detect on second synchroniser stage only
    for (int q = 0; q < 2; q++) begin
      edge_hit[q] = 1'b0;
    end
    edge_hit[0] = (mode_of(s_reg.q1_ctrl) == QM_RISE &&
                   s_reg.tr_s2[0] && !s_reg.tr_d[0]) ||
                  (mode_of(s_reg.q1_ctrl) == QM_FALL &&
                   !s_reg.tr_s2[0] && s_reg.tr_d[0]);
    edge_hit[1] = (mode_of(s_reg.queue2_control_reg) == QM_RISE &&
                   s_reg.tr_s2[1] && !s_reg.tr_d[1]) ||
                  (mode_of(s_reg.queue2_control_reg) == QM_FALL &&
                   !s_reg.tr_s2[1] && s_reg.tr_d[1]);

    // Periodic timer runs freely while queue 2 is in periodic mode
    per_tick = 1'b0;
    if (mode_of(s_reg.queue2_control_reg) == QM_PER) begin
      if (s_reg.per_cnt == 17'h0) begin
        per_tick = 1'b1;
        s_next.per_cnt =
          per_reload(s_reg.queue2_control_reg[`QC_RATE_LSB +: 4]);
      end else begin
        s_next.per_cnt = s_reg.per_cnt - 17'h1;
      end
    end else begin
      s_next.per_cnt =
        per_reload(s_reg.queue2_control_reg[`QC_RATE_LSB +: 4]);
    end

    // Software continuous mode re-triggers itself at the end or pause
    trig[0] = edge_hit[0] ||
              (mode_of(s_reg.q1_ctrl) == QM_SWCON &&
               s_reg.q1_ctrl[`QC_GO_BIT] && s_reg.q1_st != ST_RUN);
    trig[1] = edge_hit[1] || per_tick ||
              (mode_of(s_reg.queue2_control_reg) == QM_SWCON &&
               s_reg.queue2_control_reg[`QC_GO_BIT] &&
               s_reg.q2_st != ST_RUN);

    // Queue 1 and queue 2 triggers
    if (trig[0]) begin
      if (s_reg.q1_st == ST_RUN) begin
        ev[`ST_Q1_OVR] = 1'b1;
      end else begin
        if (s_reg.q1_st != ST_PAUSE) begin
          s_next.q1_ptr = 4'h0;
        end
        s_next.q1_st = ST_RUN;
      end
    end
    if (trig[1]) begin
      if (s_reg.q2_st == ST_RUN) begin
        ev[`ST_Q2_OVR] = 1'b1;
      end else begin
        if (s_reg.q2_st != ST_PAUSE) begin
          s_next.q2_ptr = 4'h0;
        end
        s_next.q2_st = ST_RUN;
      end
    end

    // Converter: one command word at a time, queue 1 first
    cur_ptr   = s_reg.active_q2 ? s_reg.q2_ptr : s_reg.q1_ptr;
    cur_pause = s_reg.active_q2 ?
                s_reg.queue2_control_reg[`QC_PAUSE_LSB + cur_ptr[2:0]] :
                s_reg.q1_ctrl[`QC_PAUSE_LSB + cur_ptr[2:0]];
    cur_last  = cur_ptr == (s_reg.active_q2 ? s_reg.q2_len : s_reg.q1_len);
    conv_end  = s_reg.busy && s_reg.conv_cnt == 8'h0;
    if (s_reg.busy) begin
      s_next.conv_cnt = s_reg.conv_cnt - 8'h1;
    end
    if (conv_end) begin
      s_next.busy = 1'b0;
      if (s_reg.active_q2) begin
        s_next.q2_ptr = s_reg.q2_ptr + 4'h1;
        if (cur_last) begin
          s_next.q2_st = ST_DONE;
          ev[`ST_Q2_DONE] = 1'b1;
        end else if (cur_pause) begin
          s_next.q2_st = ST_PAUSE;
          ev[`ST_Q2_PAUSE] = 1'b1;
        end
      end else begin
        s_next.q1_ptr = s_reg.q1_ptr + 4'h1;
        if (cur_last) begin
          s_next.q1_st = ST_DONE;
          ev[`ST_Q1_DONE] = 1'b1;
        end else if (cur_pause) begin
          s_next.q1_st = ST_PAUSE;
        end
      end
    end else if (!s_reg.busy) begin
      // Queue 2 starts only when queue 1 is not running
      if (s_reg.q1_st == ST_RUN) begin
        s_next.busy = 1'b1;
        s_next.active_q2 = 1'b0;
        s_next.conv_cnt = 8'(CONV_LEN - 1);
      end else if (s_reg.q2_st == ST_RUN && !trig[0]) begin
        s_next.busy = 1'b1;
        s_next.active_q2 = 1'b1;
        s_next.conv_cnt = 8'(CONV_LEN - 1);
      end
    end

    s_next.status = s_reg.status | ev;

    // Register writes
    if (wr) begin
      unique case (PADDR)
        `OFS_PORTA_DATA: s_next.porta_data_reg = PWDATA[7:0];
        `OFS_PORTA_DIR:  s_next.porta_direction_reg = PWDATA[7:0];
        `OFS_Q1_CTRL:    s_next.q1_ctrl = PWDATA[16:0];
        `OFS_Q2_CTRL: begin
          s_next.queue2_control_reg = PWDATA[16:0];
          s_next.per_cnt = per_reload(PWDATA[`QC_RATE_LSB +: 4]);
        end
        `OFS_MASK:       s_next.mask = PWDATA[4:0];
        `OFS_Q1_LEN:     s_next.q1_len = PWDATA[3:0];
        `OFS_Q2_LEN:     s_next.q2_len = PWDATA[3:0];
        default: ;
      endcase
      if (PADDR == `OFS_Q1_CTRL && mode_of(PWDATA[16:0]) == QM_OFF) begin
        s_next.q1_st = ST_IDLE;
      end
      if (PADDR == `OFS_Q2_CTRL && mode_of(PWDATA[16:0]) == QM_OFF) begin
        s_next.q2_st = ST_IDLE;
      end
    end

    // Register reads; a status read clears only bits seen set
    if (rd) begin
      unique case (PADDR)
        `OFS_PORTA_DATA: s_next.rdata = {24'h0,
          (s_reg.porta_direction_reg & s_reg.porta_data_reg) |
          (~s_reg.porta_direction_reg & s_reg.pa_s2)};
        `OFS_PORTA_DIR:  s_next.rdata = {24'h0, s_reg.porta_direction_reg};
        `OFS_PORTB_DATA: s_next.rdata = {24'h0, s_reg.pb_s2};
        `OFS_Q1_CTRL:    s_next.rdata = {15'h0, s_reg.q1_ctrl};
        `OFS_Q2_CTRL:    s_next.rdata = {15'h0, s_reg.queue2_control_reg};
        `OFS_STATUS: begin
          s_next.rdata = {27'h0, s_reg.status};
          // Set wins: an event in the clearing cycle survives
          s_next.status = ev;
        end
        `OFS_MASK:       s_next.rdata = {27'h0, s_reg.mask};
        `OFS_Q1_LEN:     s_next.rdata = {28'h0, s_reg.q1_len};
        `OFS_Q2_LEN:     s_next.rdata = {28'h0, s_reg.q2_len};
        `OFS_QSTATE:     s_next.rdata = {16'h0, s_reg.q2_ptr, s_reg.q1_ptr,
                                         s_reg.q2_st, s_reg.q1_st};
        default:         s_next.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg <= '{q1_st: ST_IDLE, q2_st: ST_IDLE,
                 q1_len: `QLEN_RESET, q2_len: `QLEN_RESET,
                 per_cnt: 17'h7f, default: '0};
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign PREADY  = s_reg.ack;
  assign PRDATA  = s_reg.rdata;
  assign PSLVERR = 1'b0;
  // Open drain: only ever drive low, enable where output and data zero
  assign PORTA_PINS_OUT = 8'h00;
  assign PORTA_PINS_OE  = s_reg.porta_direction_reg &
                          ~s_reg.porta_data_reg;
  assign CMD_INDEX1   = {s_reg.busy && s_reg.active_q2,
                         s_reg.busy && !s_reg.active_q2};
  assign CMD_INDEX_Q1 = s_reg.q1_ptr;
  assign CMD_INDEX_Q2 = s_reg.q2_ptr;
  assign CONV_BUSY    = s_reg.busy;
  assign IRQ = |(s_reg.status & s_reg.mask);

endmodule

//--- dv/adcq_props.sv
module adcq_props
  import adcq_pkg::*;
#(
  parameter int CONV_LEN = 14
) (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic [7:0]  PORTA_PINS_OUT,
  input wire logic [7:0]  PORTA_PINS_OE,
  input wire logic [1:0]  CMD_INDEX1,
  input wire logic [3:0]  CMD_INDEX_Q1,
  input wire logic [3:0]  CMD_INDEX_Q2,
  input wire logic        CONV_BUSY,
  input wire logic        IRQ
);
  logic [1:0] wr_h;
  logic [1:0] acc_h;
  // Two deep: register-derived outputs may lag the access edge by one
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_h  <= 2'h0;
      acc_h <= 2'h0;
    end else begin
      wr_h  <= {wr_h[0], PSEL & PENABLE & PWRITE};
      acc_h <= {acc_h[0], PSEL & PENABLE};
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_irq_up;
    $rose(IRQ);
  endsequence
  property p_irq_cause;
    s_irq_up |-> $past(CONV_BUSY) || $past(CONV_BUSY, 2) || (|acc_h);
  endproperty
  AST_PORTA_NO_HIGH: assert property (PORTA_PINS_OUT == 8'h00)
    else $error("port A drives high");
  AST_OE_BY_WRITE: assert property ($changed(PORTA_PINS_OE) |-> |wr_h)
    else $error("port A enable changed without write");
  AST_ONE_CONV: assert property ($onehot0(CMD_INDEX1))
    else $error("both queues converting");
  AST_Q1_STEP: assert property ($changed(CMD_INDEX_Q1) |->
    CMD_INDEX_Q1 == 4'($past(CMD_INDEX_Q1) + 1) || CMD_INDEX_Q1 == 4'h0)
    else $error("queue 1 pointer skipped");
  AST_Q2_STEP: assert property ($changed(CMD_INDEX_Q2) |->
    CMD_INDEX_Q2 == 4'($past(CMD_INDEX_Q2) + 1) || CMD_INDEX_Q2 == 4'h0)
    else $error("queue 2 pointer skipped");
  AST_IRQ_RISE: assert property (p_irq_cause)
    else $error("interrupt rose without cause");
  AST_IRQ_FALL: assert property ($fell(IRQ) |-> |acc_h)
    else $error("interrupt fell without access");
  AST_RD_HOLD: assert property ($changed(PRDATA) |-> |acc_h)
    else $error("read data changed without access");
endmodule
bind adc_queue_ctrl adcq_props #(.CONV_LEN(CONV_LEN)) u_props (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PRDATA(PRDATA), .PORTA_PINS_OUT(PORTA_PINS_OUT),
  .PORTA_PINS_OE(PORTA_PINS_OE), .CMD_INDEX1(CMD_INDEX1),
  .CMD_INDEX_Q1(CMD_INDEX_Q1), .CMD_INDEX_Q2(CMD_INDEX_Q2),
  .CONV_BUSY(CONV_BUSY), .IRQ(IRQ));

//--- dv/adcq_pin_model.sv
module adcq_pin_model (
  input  wire logic [7:0] OE,
  input  wire logic [7:0] OUT,
  input  wire logic [7:0] EXT_LOW,
  output logic      [7:0] LEVEL
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-ups hold released pins high; any party may pull low
  assign LEVEL = (OE & OUT) | (~OE & ~EXT_LOW);
endmodule

//--- dv/adc_queue_ctrl_tb_top.sv
`include "adcq_params.svh"
module adc_queue_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic        busy, irq;
  logic [7:0]  paddr, pa_in, pa_out, pa_oe, pb, ext_low;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  trig, cidx;
  logic [3:0]  p1, p2;
  int          failures, n_checks, q1n, q2n;
  adc_queue_ctrl uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PORTA_PINS_IN(pa_in), .PORTA_PINS_OUT(pa_out), .PORTA_PINS_OE(pa_oe),
    .PORTB_PINS(pb), .TRIG_PINS(trig), .CMD_INDEX1(cidx),
    .CMD_INDEX_Q1(p1), .CMD_INDEX_Q2(p2), .CONV_BUSY(busy), .IRQ(irq));
  adcq_pin_model pins (.OE(pa_oe), .OUT(pa_out), .EXT_LOW(ext_low),
    .LEVEL(pa_in));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    rd = prdata;
  endtask
  task automatic pulse();
    trig[0] <= 1'b1;
    repeat (4) @(posedge clk);
    trig[0] <= 1'b0;
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 500 && irq !== 1'b1; n++) @(posedge clk);
    check("irq_set", irq, 1'b1);
  endtask
  //////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, trig} = '0;
    {failures, n_checks, q1n, q2n} = '0;
    ce = 1'b1;
    ext_low = 8'h30;
    pb = 8'ha5;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1, `OFS_PORTA_DIR, 32'h0f);
    apb(1, `OFS_PORTA_DATA, 32'h05);
    @(posedge clk);
    check("oe", pa_oe, 8'h0a);
    check("out", pa_out, 8'h00);
    apb(0, `OFS_PORTA_DATA, 0);
    check("pa_rd", rd & 32'hf0, 32'hc0);
    ext_low <= 8'h80;
    apb(0, `OFS_PORTA_DATA, 0);
    check("pa_sync", rd & 32'hf0, 32'h70);
    apb(0, `OFS_PORTB_DATA, 0);
    check("pb_rd", rd, 32'ha5);
    check("slverr", pslverr, 1'b0);
    pb <= 8'h3c;
    apb(1, `OFS_PORTB_DATA, 0);
    apb(0, `OFS_PORTB_DATA, 0);
    check("pb_ro", rd, 32'h3c);
    apb(0, 8'h3c, 0);
    check("unmapped", rd, 32'h0);
    apb(1, `OFS_MASK, 32'h0f);
    apb(1, `OFS_Q1_LEN, 32'h1);
    for (int m = 2; m <= 3; m++) begin
      apb(1, `OFS_Q1_CTRL, m);
      pulse();
      wait_irq();
      apb(0, `OFS_STATUS, 0);
      check("edge_start", rd, 32'h1);
      check("irq_clr", irq, 1'b0);
      check("q1_ptr", p1, 4'h2);
      pulse();
      wait_irq();
      apb(0, `OFS_STATUS, 0);
      check("restart", rd, 32'h1);
      pulse();
      repeat (6) @(posedge clk);
      pulse();
      repeat (80) @(posedge clk);
      apb(0, `OFS_STATUS, 0);
      check("overrun", rd, 32'h5);
    end
    apb(1, `OFS_Q1_CTRL, 0);
    apb(1, `OFS_Q2_LEN, 32'h1);
    apb(1, `OFS_Q2_CTRL, 32'h104);
    repeat (200) @(posedge clk);
    apb(0, `OFS_STATUS, 0);
    check("paused", rd, 32'h10);
    repeat (95) @(posedge clk);
    apb(0, `OFS_STATUS, 0);
    check("per_done", rd, 32'h2);
    apb(1, `OFS_Q1_CTRL, 32'h10001);
    repeat (600) begin
      @(posedge clk);
      q1n += int'(cidx[0] === 1'b1);
      q2n += int'(cidx[1] === 1'b1);
    end
    check("q1_runs", q1n != 0, 1);
    check("q2_starved", q2n, 0);
    apb(1, `OFS_Q1_CTRL, 0);
    apb(1, `OFS_Q2_CTRL, 0);
    complete_run();
  end
  initial begin
    #(25ns * 20000);
    failures++;
    complete_run();
  end
endmodule
